/* logic/acr_convert_read_port.sv */
// Conversion control and parallel result readout of a 12-bit converter.
// Assumes all pins are asynchronous; the converter core answers on clk.
// Contract
// - 12-bit port; strap high gives word mode, low gives byte mode.
// - A falling conversion-start edge begins a conversion.
// - Busy rises after that edge and stays high during conversion.
// - Start returning high before 14th clock fall aborts to track.
// - Busy falls when conversion completes.
// - After power-on hold until one start rising edge gives track.
// - Hold on start fall; track again on 13th conversion clock rise.
// - Auto power modes power down at end, power up on start rise.
// - Word mode returns all twelve bits, ninth pin a data bit.
// - Byte mode: ninth pin is high byte select, two 8-bit reads.
// - Select low returns the eight low result bits.
// - High byte: four top bits, channel on bits 5:4, bits 7:6 zero.
// - Chip select and read strobe combine as active-low levels.
// - Drive only while both low; release after read strobe rises.
// - Held low, valid result appears shortly before busy falls.
// - Control writes latch on write strobe rise, one or two writes.
`default_nettype none
`include "acr_defs.svh"
module acr_convert_read_port
    import acr_pkg::*;
(
    input wire logic clk,                            // 100 MHz clock
    input wire logic nrst,                           // Async reset
    input wire logic conv_start_n,                   // Start strobe pin
    input wire logic conv_clock_in,                  // Conversion clock pin
    input wire logic chipSel_n,                      // Chip select pin
    input wire logic readStrobe_n,                   // Read strobe pin
    input wire logic writeStrobe_n,                  // Write strobe pin
    input wire logic wordByteSel,                    // Strap, high = word
    input wire logic [`ACR_DATA_W-1:0] dataIn,       // Bus pins in; bit 8 is shared_ninth_pin
    input wire logic [`ACR_DATA_W-1:0] coreResult,   // Converter core word
    input wire logic [`ACR_CHAN_W-1:0] coreChannel,  // Channel being sampled
    output logic [`ACR_DATA_W-1:0] dataOut,          // Bus pins out
    output logic lowOe_n,                            // Enable bits 7:0, low drives
    output logic highOe_n,                           // Enable bits 11:8, low drives
    output logic busy,                               // Conversion in progress
    output logic track,                              // Sampling stage tracks
    output logic powerDown,                          // Core powered down
    output logic [`ACR_DATA_W-1:0] ctrlWord          // Control register
);
    logic [`ACR_SYNC_W-1:0] syncA;
    logic [`ACR_SYNC_W-1:0] syncB;
    logic [`ACR_SYNC_W-1:0] prevB;
    logic [`ACR_DATA_W-1:0] pinData;
    logic cst, cclk, readActive, wrAct, strapNow;
    logic cstFall, cstRise, clkFall, clkRise, wrRise, highByteSel;
    logic wordMode, strapTaken;
    logic next_wordMode, next_strapTaken;
    logic [1:0] settleCnt, next_settleCnt;
    acr_state_type state, next_state;
    logic [`ACR_CNT_W-1:0] fallCnt, riseCnt, next_fallCnt, next_riseCnt;
    logic next_busy, next_track, next_powerDown, load, autoMode;
    logic [`ACR_DATA_W-1:0] next_ctrlWord, next_dataOut;
    logic next_lowOe_n, next_highOe_n;
    logic [`ACR_DATA_W-1:0] storeResult;
    logic [`ACR_CHAN_W-1:0] storeChan;

    // Two-stage synchronisers, third stage for edges
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            syncA <= {`ACR_SYNC_W{1'b1}};
            syncB <= {`ACR_SYNC_W{1'b1}};
            prevB <= {`ACR_SYNC_W{1'b1}};
        end
        else
        begin
            syncA <= {wordByteSel, writeStrobe_n, readStrobe_n, chipSel_n,
                      conv_clock_in, conv_start_n, dataIn};
            syncB <= syncA;
            prevB <= syncB;
        end
    end

    assign pinData = syncB[11:0];
    assign cst = syncB[12];
    assign cclk = syncB[13];
    assign readActive = !syncB[15] && !syncB[14];
    assign wrRise = !prevB[14] && !prevB[16] && syncB[16];
    // Chip select must still be low when the write strobe rises
    assign wrAct = wrRise && !syncB[14];
    assign strapNow = syncB[17];
    assign cstFall = prevB[12] && !cst;
    assign cstRise = !prevB[12] && cst;
    assign clkFall = prevB[13] && !cclk;
    assign clkRise = !prevB[13] && cclk;
    assign highByteSel = pinData[8];
    assign autoMode = ctrlWord[`ACR_PM_LSB+1:`ACR_PM_LSB] != `ACR_PM_NORMAL;
    assign load = state == ST_CONV && clkFall && fallCnt == `ACR_LOAD_FALL - 4'h1;

    acr_result_store u_store
    (
        .clk(clk),
        .nrst(nrst),
        .load(load),
        .resultIn(coreResult),
        .chanIn(coreChannel),
        .result(storeResult),
        .chan(storeChan)
    );

    // Conversion sequencing
    always_comb
    begin
        next_state = state;
        next_fallCnt = fallCnt;
        next_riseCnt = riseCnt;
        next_busy = busy;
        next_track = track;
        next_powerDown = powerDown;
        case (state)
            ST_HOLD:
            begin
                if (cstRise)
                begin
                    next_state = ST_TRACK;
                    next_track = 1'b1;
                end
            end
            ST_TRACK:
            begin
                if (cstFall)
                begin
                    next_state = ST_CONV;
                    next_busy = 1'b1;
                    next_track = 1'b0;
                    next_fallCnt = '0;
                    next_riseCnt = '0;
                end
            end
            ST_CONV:
            begin
                if (clkRise)
                begin
                    next_riseCnt = riseCnt + 4'h1;
                    if (riseCnt == `ACR_TRACK_RISE - 4'h1)
                    begin
                        next_track = 1'b1;
                    end
                end
                if (cstRise && fallCnt < `ACR_DONE_FALL)
                begin
                    next_state = ST_TRACK;
                    next_busy = 1'b0;
                    next_track = 1'b1;
                end
                else if (clkFall)
                begin
                    next_fallCnt = fallCnt + 4'h1;
                    if (fallCnt == `ACR_DONE_FALL - 4'h1)
                    begin
                        next_busy = 1'b0;
                        if (autoMode)
                        begin
                            next_state = ST_DOWN;
                            next_powerDown = 1'b1;
                            next_track = 1'b0;
                        end
                        else
                        begin
                            next_state = ST_TRACK;
                            next_track = 1'b1;
                        end
                    end
                end
            end
            ST_DOWN:
            begin
                if (cstRise)
                begin
                    next_state = ST_TRACK;
                    next_powerDown = 1'b0;
                    next_track = 1'b1;
                end
            end
            default:
            begin
                next_state = ST_HOLD;
                next_track = 1'b0;
                next_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= ST_HOLD;
            fallCnt <= '0;
            riseCnt <= '0;
            busy <= 1'b0;
            track <= 1'b0;
            powerDown <= 1'b0;
        end
        else
        begin
            state <= next_state;
            fallCnt <= next_fallCnt;
            riseCnt <= next_riseCnt;
            busy <= next_busy;
            track <= next_track;
            powerDown <= next_powerDown;
        end
    end

    // Strap capture, control writes and read drive
    always_comb
    begin
        // Strap taken only once the synchroniser holds the pin, not its reset value
        next_settleCnt = (settleCnt == `ACR_SETTLE) ? settleCnt : settleCnt + 2'h1;
        next_strapTaken = settleCnt == `ACR_SETTLE;
        next_wordMode = strapTaken ? wordMode : strapNow;
        next_ctrlWord = ctrlWord;
        if (wrAct)
        begin
            if (wordMode)
            begin
                next_ctrlWord = pinData;
            end
            else if (highByteSel)
            begin
                next_ctrlWord[11:8] = pinData[3:0];
            end
            else
            begin
                next_ctrlWord[7:0] = pinData[7:0];
            end
        end
        next_lowOe_n = !readActive;
        next_highOe_n = !(readActive && wordMode);
        if (wordMode)
        begin
            next_dataOut = storeResult;
        end
        else if (highByteSel)
        begin
            next_dataOut = {4'h0, 2'h0, storeChan, storeResult[11:8]};
        end
        else
        begin
            next_dataOut = {4'h0, storeResult[7:0]};
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            settleCnt <= 2'h0;
            strapTaken <= 1'b0;
            wordMode <= 1'b0;
            ctrlWord <= `ACR_CTRL_RESET;
            lowOe_n <= 1'b1;
            highOe_n <= 1'b1;
            dataOut <= '0;
        end
        else
        begin
            settleCnt <= next_settleCnt;
            strapTaken <= next_strapTaken;
            wordMode <= next_wordMode;
            ctrlWord <= next_ctrlWord;
            lowOe_n <= next_lowOe_n;
            highOe_n <= next_highOe_n;
            dataOut <= next_dataOut;
        end
    end

    sequence s_start;
        state == ST_TRACK && cstFall;
    endsequence
    sequence s_converting;
        busy && !track;
    endsequence

    property p_start;
        @(posedge clk) disable iff (!nrst) s_start |=> s_converting;
    endproperty
    a_start: assert property (p_start) else $error("No busy/hold on start");

    property p_abort;
        @(posedge clk) disable iff (!nrst)
            state == ST_CONV && cstRise && fallCnt < 4'he |=> !busy && track;
    endproperty
    a_abort: assert property (p_abort) else $error("Early start rise did not abort");

    property p_done;
        @(posedge clk) disable iff (!nrst)
            state == ST_CONV && !cstRise && clkFall && fallCnt == 4'hd |=> !busy ##1 !busy;
    endproperty
    a_done: assert property (p_done) else $error("Busy did not fall at end");

    property p_hold_power_on;
        @(posedge clk) disable iff (!nrst)
            state == ST_HOLD && !cstRise |=> !track && state == ST_HOLD;
    endproperty
    a_hold_power_on: assert property (p_hold_power_on) else $error("Left hold early");

    property p_track13;
        @(posedge clk) disable iff (!nrst)
            state == ST_CONV && clkRise && riseCnt == 4'hc |=> track;
    endproperty
    a_track13: assert property (p_track13) else $error("No track at 13th rise");

    property p_autodown;
        @(posedge clk) disable iff (!nrst)
            state == ST_CONV && !cstRise && clkFall && fallCnt == 4'hd && autoMode
            |=> powerDown && !track;
    endproperty
    a_autodown: assert property (p_autodown) else $error("No power down");

    property p_drive;
        @(posedge clk) disable iff (!nrst)
            readActive |=> !lowOe_n;
    endproperty
    a_drive: assert property (p_drive) else $error("Bus drive wrong");

    property p_release;
        @(posedge clk) disable iff (!nrst)
            !readActive |=> lowOe_n && highOe_n;
    endproperty
    a_release: assert property (p_release) else $error("Bus not released");

    property p_high_byte;
        @(posedge clk) disable iff (!nrst)
            !wordMode && highByteSel |=>
            dataOut[7:4] == {2'h0, $past(storeChan)} && dataOut[3:0] == $past(storeResult[11:8]);
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("High byte wrong");

    property p_word;
        @(posedge clk) disable iff (!nrst)
            wordMode && readActive |=> dataOut == $past(storeResult) && !highOe_n;
    endproperty
    a_word: assert property (p_word) else $error("Word read wrong");

    property p_load_before_busy;
        @(posedge clk) disable iff (!nrst)
            load |=> storeResult == $past(coreResult) ##[1:300] !busy;
    endproperty
    a_load_before_busy: assert property (p_load_before_busy) else $error("Result late");
endmodule
`default_nettype wire

/* logic/acr_result_store.sv */
// Result word and channel number of the last conversion.
// Assumes load is a one-cycle pulse on the same clock.
`default_nettype none
`include "acr_defs.svh"
module acr_result_store
(
    input wire logic clk,                            // System clock
    input wire logic nrst,                           // Async reset
    input wire logic load,                           // Capture pulse
    input wire logic [`ACR_DATA_W-1:0] resultIn,     // Converter word
    input wire logic [`ACR_CHAN_W-1:0] chanIn,       // Sampled channel
    output logic [`ACR_DATA_W-1:0] result,           // Stored word
    output logic [`ACR_CHAN_W-1:0] chan              // Stored channel
);
    logic [`ACR_DATA_W-1:0] next_result;
    logic [`ACR_CHAN_W-1:0] next_chan;

    always_comb
    begin
        next_result = load ? resultIn : result;
        next_chan = load ? chanIn : chan;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            result <= '0;
            chan <= '0;
        end
        else
        begin
            result <= next_result;
            chan <= next_chan;
        end
    end
endmodule
`default_nettype wire

/* pkg/acr_defs.svh */
// Constants of the converter control and read port.
// Assumes inclusion by the top module and the result store only.
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

`define ACR_DATA_W 12
`define ACR_CHAN_W 2
`define ACR_CNT_W 4
`define ACR_SYNC_W 18
// Edges until the strap has passed both synchroniser stages
`define ACR_SETTLE 2'h2
// Conversion clock edge counts
`define ACR_TRACK_RISE 4'hd
`define ACR_DONE_FALL 4'he
`define ACR_LOAD_FALL 4'hd
// Control word power field
`define ACR_PM_LSB 4
`define ACR_PM_NORMAL 2'h0
`define ACR_CTRL_RESET 12'h000

`endif

/* pkg/acr_pkg.sv */
// Types of the converter control and read port.
// Assumes nothing beyond the constants header.
`default_nettype none
package acr_pkg;
    typedef enum logic [3:0]
    {
        ST_HOLD  = 4'h1,
        ST_TRACK = 4'h2,
        ST_CONV  = 4'h4,
        ST_DOWN  = 4'h8
    } acr_state_type;
endpackage
`default_nettype wire

/* verification/acr_host_model.sv */
// Host side of the converter port: conversion clock and bus wires.
// Assumes the bench drives its own bus bits through hostDrive and hostData.
`default_nettype none
module acr_host_model
(
    input wire logic clk,                 // System clock
    input wire logic clkRun,              // Run conversion clock
    input wire logic [11:0] hostData,     // Host bus value
    input wire logic [11:0] hostDrive,    // Host drives bit when high
    input wire logic [11:0] dataOut,      // Device bus value
    input wire logic lowOe_n,             // Device drives 7:0 when low
    input wire logic highOe_n,            // Device drives 11:8 when low
    output logic [11:0] busWire,          // Resolved bus
    output logic convClock,               // Conversion clock pin
    output int riseCnt,                   // Clock rises since run
    output int fallCnt                    // Clock falls since run
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0] lastBus;
    logic [1:0] phase;

    // Slow clock, still outside conversions
    always_ff @(negedge clk)
    begin
        if (!clkRun)
        begin
            phase <= 2'h0;
            convClock <= 1'b0;
            riseCnt <= 0;
            fallCnt <= 0;
        end
        else
        begin
            phase <= phase + 2'h1;
            if (phase == 2'h3)
            begin
                convClock <= !convClock;
                if (convClock)
                    fallCnt <= fallCnt + 1;
                else
                    riseCnt <= riseCnt + 1;
            end
        end
    end

    // Released bits show the inverse of their last level
    always_comb
    begin
        for (int i = 0; i < 12; i++)
        begin
            if (hostDrive[i])
                busWire[i] = hostData[i];
            else if (i < 8 ? !lowOe_n : !highOe_n)
                busWire[i] = dataOut[i];
            else
                busWire[i] = ~lastBus[i];
        end
    end

    always_ff @(posedge clk)
        lastBus <= busWire;
endmodule
`default_nettype wire

/* verification/test_acr_convert_read_port.sv */
// Bench for the converter control and read port.
// Assumes the host model makes the conversion clock and resolves the bus.
`default_nettype none
`define CHECK(what, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
        end \
    end
module test_acr_convert_read_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, nrst = 1'b0, conv_start_n = 1'b0, convClock, clkRun = 1'b0;
    logic chipSel_n = 1'b1, readStrobe_n = 1'b1, writeStrobe_n = 1'b1, wordByteSel = 1'b1;
    logic [11:0] hostData = 12'h000, hostDrive = 12'h000, busWire, dataOut, ctrlWord;
    logic [11:0] coreResult = 12'h000;
    logic [1:0] coreChannel = 2'h0;
    logic lowOe_n, highOe_n, busy, track, powerDown;
    int riseCnt, fallCnt, failures = 0, n_tests = 0, cycles = 0;

    always #5 clk = ~clk;

    acr_host_model host (.clk(clk), .clkRun(clkRun), .hostData(hostData),
        .hostDrive(hostDrive), .dataOut(dataOut), .lowOe_n(lowOe_n), .highOe_n(highOe_n),
        .busWire(busWire), .convClock(convClock), .riseCnt(riseCnt), .fallCnt(fallCnt));

    acr_convert_read_port dut (.clk(clk), .nrst(nrst), .conv_start_n(conv_start_n),
        .conv_clock_in(convClock), .chipSel_n(chipSel_n), .readStrobe_n(readStrobe_n),
        .writeStrobe_n(writeStrobe_n), .wordByteSel(wordByteSel), .dataIn(busWire),
        .coreResult(coreResult), .coreChannel(coreChannel), .dataOut(dataOut),
        .lowOe_n(lowOe_n), .highOe_n(highOe_n), .busy(busy), .track(track),
        .powerDown(powerDown), .ctrlWord(ctrlWord));

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Reset with the start pin low, then the first rise leaves hold
    task automatic power_on(input logic word);
        nrst = 1'b0;
        wordByteSel = word;
        conv_start_n = 1'b0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (10) @(negedge clk);
        `CHECK("hold", 1'b0, track)
        `CHECK("idle", 1'b0, busy)
        conv_start_n = 1'b1;
        repeat (5) @(negedge clk);
        `CHECK("first track", 1'b1, track)
        $display("power on done");
    endtask

    task automatic write_ctrl(input logic [11:0] value, input logic [11:0] drive);
        hostDrive = drive;
        hostData = value;
        chipSel_n = 1'b0;
        writeStrobe_n = 1'b0;
        repeat (4) @(negedge clk);
        writeStrobe_n = 1'b1;
        repeat (4) @(negedge clk);
        chipSel_n = 1'b1;
        hostDrive = 12'h000;
        repeat (4) @(negedge clk);
    endtask

    task automatic convert(input logic [11:0] res, input logic [1:0] ch,
                           input logic auto, input logic hold);
        int i;
        logic [11:0] prevBus;
        coreResult = res;
        coreChannel = ch;
        chipSel_n = !hold;
        readStrobe_n = !hold; // Held low when hold is set, high otherwise; never pulsed mid-conversion
        repeat (13) @(negedge clk); // Acquisition time
        conv_start_n = 1'b0;
        repeat (4) @(negedge clk);
        `CHECK("busy", 1'b1, busy)
        `CHECK("hold", 1'b0, track)
        clkRun = 1'b1;
        for (i = 0; i < 200 && track !== 1'b1; i++)
            @(negedge clk);
        `CHECK("rises", 13, riseCnt)
        `CHECK("busy mid", 1'b1, busy)
        for (i = 0; i < 200 && busy !== 1'b0; i++)
        begin
            prevBus = busWire;
            @(negedge clk);
        end
        `CHECK("falls", 14, fallCnt)
        if (hold)
            `CHECK("early bus", res, prevBus)
        `CHECK("power down", auto, powerDown)
        `CHECK("track end", !auto, track)
        clkRun = 1'b0;
        conv_start_n = 1'b1; // Only after the 14th fall
        repeat (5) @(negedge clk);
        `CHECK("powered", 1'b0, powerDown)
        `CHECK("tracking", 1'b1, track)
        $display("conversion done");
    endtask

    task automatic word_release();
        `CHECK("low drive", 1'b0, lowOe_n)
        `CHECK("high drive", 1'b0, highOe_n)
        readStrobe_n = 1'b1;
        repeat (4) @(negedge clk);
        `CHECK("low off", 1'b1, lowOe_n)
        `CHECK("high off", 1'b1, highOe_n)
        chipSel_n = 1'b1;
        $display("word read done");
    endtask

    task automatic abort_conv();
        int i;
        repeat (13) @(negedge clk);
        conv_start_n = 1'b0;
        repeat (4) @(negedge clk);
        clkRun = 1'b1;
        for (i = 0; i < 200 && fallCnt < 5; i++)
            @(negedge clk);
        conv_start_n = 1'b1;
        repeat (5) @(negedge clk);
        `CHECK("abort busy", 1'b0, busy)
        `CHECK("abort track", 1'b1, track)
        clkRun = 1'b0;
        $display("abort done");
    endtask

    task automatic byte_read(input logic sel, input logic [7:0] exp);
        hostDrive = 12'h100;
        hostData = {3'h0, sel, 8'h00};
        chipSel_n = 1'b0;
        readStrobe_n = 1'b0;
        repeat (4) @(negedge clk);
        `CHECK("byte", exp, busWire[7:0])
        `CHECK("upper off", 1'b1, highOe_n)
        readStrobe_n = 1'b1;
        chipSel_n = 1'b1;
        repeat (4) @(negedge clk);
        `CHECK("byte off", 1'b1, lowOe_n)
        hostDrive = 12'h000;
        $display("byte read done");
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            stop_test();
        end
    end

    initial
    begin
        power_on(1'b1);
        write_ctrl(12'h3c3, 12'hfff);
        `CHECK("word write", 12'h3c3, ctrlWord)
        convert(12'ha5c, 2'h2, 1'b0, 1'b1);
        word_release();
        abort_conv();
        power_on(1'b0);
        write_ctrl(12'h010, 12'h1ff);
        write_ctrl(12'h102, 12'h1ff); // Upper high-byte bits zero
        `CHECK("byte write", 12'h210, ctrlWord)
        convert(12'h3b7, 2'h1, 1'b1, 1'b0);
        byte_read(1'b0, 8'hb7);
        byte_read(1'b1, 8'h13);
        stop_test();
    end
endmodule
`default_nettype wire
